// ==== pkg/core_regs_pkg.sv ====
// Constants and carrier types for the core special-function register block.
// Assumes an execution unit on the same clock and a Wishbone master.
package core_regs_pkg;

  // ==========================================================
  // Register addresses (sector 0 byte locations)
  localparam logic [7:0] ADDR_INDIRECT_0  = 8'h00;
  localparam logic [7:0] ADDR_PTR_SECTOR0 = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_1  = 8'h02;
  localparam logic [7:0] ADDR_PTR1_LOW    = 8'h03;
  localparam logic [7:0] ADDR_PTR1_SECTOR = 8'h04;
  localparam logic [7:0] ADDR_ACC         = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW      = 8'h06;
  localparam logic [7:0] ADDR_TABLE_LOW   = 8'h07;
  localparam logic [7:0] ADDR_TABLE_DATA  = 8'h08;
  localparam logic [7:0] ADDR_TABLE_HIGH  = 8'h09;
  localparam logic [7:0] ADDR_ALU_FLAGS   = 8'h0a;
  localparam logic [7:0] ADDR_INDIRECT_2  = 8'h0c;
  localparam logic [7:0] ADDR_PTR2_LOW    = 8'h0d;
  localparam logic [7:0] ADDR_PTR2_SECTOR = 8'h0e;

  // ==========================================================
  // Flag bit positions in alu_flags
  localparam int BIT_CARRY  = 0;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_ZERO   = 2;
  localparam int BIT_WRAP   = 3;
  localparam int BIT_HALTED = 4;
  localparam int BIT_WDOG   = 5;
  localparam int BIT_CHAIN  = 6;
  localparam int BIT_SIGN   = 7;
  // Software may write only the low nibble
  localparam logic [7:0] FLAGS_WR_MASK = 8'h0f;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [12:0] RESET_PC     = 13'h0000;

  // ==========================================================
  // Sizes
  localparam int DMEM_WORDS = 512;
  localparam int PC_BITS    = 13;

  // ==========================================================
  // ALU operation classes
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_SBC, OP_LOGIC, OP_ROTC
  } alu_op_t;

  // Result from the execution unit
  typedef struct packed {
    alu_op_t    op;
    logic [7:0] result;
    logic       carry;     // Carry out or no-borrow
    logic       nibble;    // Nibble carry or no-borrow
    logic       carry_in7; // Carry into bit 7
  } alu_res_t;

  // Data memory access request (9-bit address)
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [8:0] addr;
    logic [7:0] wdata;
  } dmem_req_t;

endpackage

// ==== logic/core_special_registers.sv ====
// Core special-function registers: indirect ports, memory pointers,
// working register, program counter low byte, table pointers, flags.
// Assumes one 10 MHz clock, Wishbone master and execution unit alike.
//
// Overview of operation
// - Indirect port access goes to data memory at its pointer address.
// - Port 0 reaches sector 0 only; ports 1, 2 use pointer sector.
// - Indirect read of indirect port gives zero; indirect write does nothing.
// - Five pointer bytes are real storage, readable and writable.
// - Extended addresses are 9 bits: sector high part, location low byte.
// - ALU results go to working register; no register-to-register moves.
// - Program counter low write jumps within page with one dummy cycle.
// - Table read puts word high byte in latch, low byte to destination.
// - Status writes never change watchdog-expired or halted flags.
// - Watchdog flag clears on reset, clear, halt; sets on timeout.
// - Halted flag clears on reset, watchdog clear; sets on halt.
// - Outflow flag is carry or no-borrow; rotate through carry updates.
// - Nibble carry is low-nibble carry or no high-nibble borrow.
// - Result-null flag sets when the result is zero.
// - Signed wrap is carry into bit 7 xor carry out of it.
// - Sign compare is signed wrap xor result bit 7.
// - Calls and interrupts do not stack the flag register.
// - Flags bit 7 to 0: sign, chain, wdog, halted, wrap, zero, nibble, carry.
// - Subtract without borrow copies result-null into chained zero.
// - Subtract with borrow ANDs chained zero with zero result.
//
// Chosen here: the register offsets and the Wishbone slave port.
module core_special_registers (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave, byte registers in the low lane
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [31:0]                wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // Execution unit
  input  wire core_regs_pkg::alu_res_t    alu_i,
  input  wire logic                       alu_valid_i,
  input  wire logic                       wdog_clear_i,
  input  wire logic                       halt_i,
  input  wire logic                       wdog_timeout_i,
  input  wire logic                       table_read_i,
  input  wire logic [15:0]                table_word_i,
  input  wire logic [4:0]                 pc_page_i,
  output logic      [7:0]                 acc_o,
  output logic      [7:0]                 alu_flags_o,
  output logic      [12:0]                jump_target_o,
  output logic                            jump_o,
  output logic                            dummy_cycle_o,
  output logic      [15:0]                table_addr_o,
  output logic      [7:0]                 table_low_o
);

  // ==========================================================
  // Storage
  logic [7:0]  dmem [core_regs_pkg::DMEM_WORDS];
  logic [7:0]  acc, next_acc;
  logic [7:0]  flags, next_flags;
  logic [7:0]  ptr0, ptr1_low, ptr1_sec, ptr2_low, ptr2_sec;
  logic [7:0]  next_ptr0, next_ptr1_low, next_ptr1_sec;
  logic [7:0]  next_ptr2_low, next_ptr2_sec;
  logic [7:0]  tbl_low, tbl_high, tbl_data;
  logic [7:0]  next_tbl_low, next_tbl_high, next_tbl_data;
  logic [7:0]  tlow_out, next_tlow_out;
  logic [12:0] jump_tgt, next_jump_tgt;
  logic        jump, next_jump, dummy, next_dummy;
  logic        ack, next_ack;
  logic [7:0]  rdat, next_rdat;

  // ==========================================================
  // Bus decode
  logic        req;
  logic        wr;
  logic [8:0]  ext_addr;
  logic [7:0]  loc;
  logic [8:0]  eff_addr;
  logic        is_indirect;
  logic        mem_wr;
  logic        lane0;
  logic [7:0]  wbyte;

  // Word address = byte address / 4; bit 8 of the word index is sector
  assign req      = wb_cyc_i && wb_stb_i && !ack;
  assign wr       = req && wb_we_i;
  assign lane0    = wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign ext_addr = wb_adr_i[10:2];
  assign loc      = ext_addr[7:0];

  // Effective address through the pointers
  always_comb begin
    eff_addr    = ext_addr;
    is_indirect = 1'b0;
    if (ext_addr[8] == 1'b0) begin
      case (loc)
        // port 0 fixed to sector 0
        core_regs_pkg::ADDR_INDIRECT_0: begin
          eff_addr    = {1'b0, ptr0};
          is_indirect = 1'b1;
        end
        // ports 1 and 2 take pointer sector
        core_regs_pkg::ADDR_INDIRECT_1: begin
          eff_addr    = {ptr1_sec[0], ptr1_low};
          is_indirect = 1'b1;
        end
        core_regs_pkg::ADDR_INDIRECT_2: begin
          eff_addr    = {ptr2_sec[0], ptr2_low};
          is_indirect = 1'b1;
        end
        default: begin
          eff_addr    = ext_addr;
          is_indirect = 1'b0;
        end
      endcase
    end
  end

  // Access through an indirect port pointing at another port returns zero
  function automatic logic is_port(input logic [8:0] a);
    is_port = (a[8] == 1'b0) &&
              (a[7:0] == core_regs_pkg::ADDR_INDIRECT_0 ||
               a[7:0] == core_regs_pkg::ADDR_INDIRECT_1 ||
               a[7:0] == core_regs_pkg::ADDR_INDIRECT_2);
  endfunction

  // Register read mux by effective address
  function automatic logic [7:0] read_reg(input logic [8:0] a,
                                          input logic [7:0] m);
    logic [7:0] v;
    v = m;
    if (a[8] == 1'b0) begin
      case (a[7:0])
        core_regs_pkg::ADDR_INDIRECT_0,
        core_regs_pkg::ADDR_INDIRECT_1,
        core_regs_pkg::ADDR_INDIRECT_2:  v = core_regs_pkg::RESET_BYTE;
        core_regs_pkg::ADDR_PTR_SECTOR0: v = ptr0;
        core_regs_pkg::ADDR_PTR1_LOW:    v = ptr1_low;
        core_regs_pkg::ADDR_PTR1_SECTOR: v = ptr1_sec;
        core_regs_pkg::ADDR_PTR2_LOW:    v = ptr2_low;
        core_regs_pkg::ADDR_PTR2_SECTOR: v = ptr2_sec;
        core_regs_pkg::ADDR_ACC:         v = acc;
        core_regs_pkg::ADDR_PC_LOW:      v = jump_tgt[7:0];
        core_regs_pkg::ADDR_TABLE_LOW:   v = tbl_low;
        core_regs_pkg::ADDR_TABLE_DATA:  v = tbl_data;
        core_regs_pkg::ADDR_TABLE_HIGH:  v = tbl_high;
        core_regs_pkg::ADDR_ALU_FLAGS:   v = flags;
        default:                         v = m;
      endcase
    end
    read_reg = v;
  endfunction

  // ==========================================================
  // Data memory: written at every address but the three ports; special registers win on reads
  // indirect writes land at the pointer address
  assign mem_wr = wr && lane0 && !is_port(eff_addr);

  always_ff @(posedge clk_i) begin
    if (mem_wr) begin
      dmem[eff_addr] <= wbyte;
    end
  end

  // ==========================================================
  // Next-state logic for bus answer and all registers
  always_comb begin
    logic [7:0] res;
    logic       zero, wrap;
    res            = alu_i.result;
    zero           = (alu_i.result == 8'h00);
    wrap           = alu_i.carry_in7 ^ alu_i.carry;
    next_ack       = req;
    next_rdat      = rdat;
    next_acc       = acc;
    next_flags     = flags;
    next_ptr0      = ptr0;
    next_ptr1_low  = ptr1_low;
    next_ptr1_sec  = ptr1_sec;
    next_ptr2_low  = ptr2_low;
    next_ptr2_sec  = ptr2_sec;
    next_tbl_low   = tbl_low;
    next_tbl_high  = tbl_high;
    next_tbl_data  = tbl_data;
    next_tlow_out  = tlow_out;
    next_jump_tgt  = {pc_page_i, jump_tgt[7:0]};
    next_jump      = 1'b0;
    next_dummy     = jump;

    // Read answer; addresses with no register behind them read data memory
    if (req && !wb_we_i) begin
      // indirect reads fetch the pointed location
      next_rdat = read_reg(eff_addr, dmem[eff_addr]);
    end

    // ALU result: the working register takes it
    if (alu_valid_i && alu_i.op != core_regs_pkg::OP_NONE) begin
      next_acc = res;
      next_flags[core_regs_pkg::BIT_ZERO] = zero;
      if (alu_i.op != core_regs_pkg::OP_LOGIC) begin
        next_flags[core_regs_pkg::BIT_CARRY] = alu_i.carry;
      end
      if (alu_i.op == core_regs_pkg::OP_ADD ||
          alu_i.op == core_regs_pkg::OP_SUB ||
          alu_i.op == core_regs_pkg::OP_SBC) begin
        next_flags[core_regs_pkg::BIT_NIBBLE] = alu_i.nibble;
        next_flags[core_regs_pkg::BIT_WRAP]   = wrap;
        next_flags[core_regs_pkg::BIT_SIGN]   = wrap ^ res[7];
      end
      if (alu_i.op == core_regs_pkg::OP_SUB) begin
        next_flags[core_regs_pkg::BIT_CHAIN] = zero;
      end
      if (alu_i.op == core_regs_pkg::OP_SBC) begin
        next_flags[core_regs_pkg::BIT_CHAIN] =
          flags[core_regs_pkg::BIT_CHAIN] & zero;
      end
    end

    // Software writes to sector 0 registers (direct or through a port)
    // pointers are ordinary storage
    if (wr && lane0 && eff_addr[8] == 1'b0) begin
      case (eff_addr[7:0])
        core_regs_pkg::ADDR_PTR_SECTOR0: next_ptr0     = wbyte;
        core_regs_pkg::ADDR_PTR1_LOW:    next_ptr1_low = wbyte;
        core_regs_pkg::ADDR_PTR1_SECTOR: next_ptr1_sec = wbyte;
        core_regs_pkg::ADDR_PTR2_LOW:    next_ptr2_low = wbyte;
        core_regs_pkg::ADDR_PTR2_SECTOR: next_ptr2_sec = wbyte;
        core_regs_pkg::ADDR_ACC:         next_acc      = wbyte;
        core_regs_pkg::ADDR_TABLE_LOW:   next_tbl_low  = wbyte;
        core_regs_pkg::ADDR_TABLE_HIGH:  next_tbl_high = wbyte;
        core_regs_pkg::ADDR_TABLE_DATA:  next_tbl_data = wbyte;
        // jump inside current page, dummy cycle follows
        core_regs_pkg::ADDR_PC_LOW: begin
          next_jump_tgt = {pc_page_i, wbyte};
          next_jump     = 1'b1;
        end
        core_regs_pkg::ADDR_ALU_FLAGS: begin
          next_flags = (next_flags & ~core_regs_pkg::FLAGS_WR_MASK) |
                       (wbyte & core_regs_pkg::FLAGS_WR_MASK);
        end
        default: begin
          next_ptr0 = next_ptr0;
        end
      endcase
    end

    // table word split between latch and destination
    if (table_read_i) begin
      next_tbl_data = table_word_i[15:8];
      next_tlow_out = table_word_i[7:0];
    end

    // watchdog flag; timeout wins over clear
    if (wdog_clear_i || halt_i) begin
      next_flags[core_regs_pkg::BIT_WDOG] = 1'b0;
    end
    if (wdog_timeout_i) begin
      next_flags[core_regs_pkg::BIT_WDOG] = 1'b1;
    end
    if (wdog_clear_i) begin
      next_flags[core_regs_pkg::BIT_HALTED] = 1'b0;
    end
    if (halt_i) begin
      next_flags[core_regs_pkg::BIT_HALTED] = 1'b1;
    end
  end

  // ==========================================================
  // Registers; flags clear at reset so power-up state is defined
  // nothing here stacks the flags on call or interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      rdat     <= core_regs_pkg::RESET_BYTE;
      acc      <= core_regs_pkg::RESET_BYTE;
      flags    <= core_regs_pkg::RESET_BYTE;
      ptr0     <= core_regs_pkg::RESET_BYTE;
      ptr1_low <= core_regs_pkg::RESET_BYTE;
      ptr1_sec <= core_regs_pkg::RESET_BYTE;
      ptr2_low <= core_regs_pkg::RESET_BYTE;
      ptr2_sec <= core_regs_pkg::RESET_BYTE;
      tbl_low  <= core_regs_pkg::RESET_BYTE;
      tbl_high <= core_regs_pkg::RESET_BYTE;
      tbl_data <= core_regs_pkg::RESET_BYTE;
      tlow_out <= core_regs_pkg::RESET_BYTE;
      jump_tgt <= core_regs_pkg::RESET_PC;
      jump     <= 1'b0;
      dummy    <= 1'b0;
    end else begin
      ack      <= next_ack;
      rdat     <= next_rdat;
      acc      <= next_acc;
      flags    <= next_flags;
      ptr0     <= next_ptr0;
      ptr1_low <= next_ptr1_low;
      ptr1_sec <= next_ptr1_sec;
      ptr2_low <= next_ptr2_low;
      ptr2_sec <= next_ptr2_sec;
      tbl_low  <= next_tbl_low;
      tbl_high <= next_tbl_high;
      tbl_data <= next_tbl_data;
      tlow_out <= next_tlow_out;
      jump_tgt <= next_jump_tgt;
      jump     <= next_jump;
      dummy    <= next_dummy;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o      = ack;
  assign wb_dat_o      = {24'h000000, rdat};
  assign acc_o         = acc;
  // flag byte order set by package bit positions
  assign alu_flags_o   = flags;
  assign jump_target_o = jump_tgt;
  assign jump_o        = jump;
  assign dummy_cycle_o = dummy;
  assign table_addr_o  = {tbl_high, tbl_low};
  assign table_low_o   = tlow_out;

  // ==========================================================
  // Checks
  sequence s_pc_low_write;
    wr && lane0 && eff_addr == {1'b0, core_regs_pkg::ADDR_PC_LOW};
  endsequence

  a_jump_then_dummy: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_pc_low_write |=> jump ##1 dummy)
    else $error("pc low write without jump and dummy");
  a_halt_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    halt_i && !wdog_clear_i |=> flags[core_regs_pkg::BIT_HALTED]
      && (!flags[core_regs_pkg::BIT_WDOG] || $past(wdog_timeout_i)))
    else $error("halt did not set halted flag");
  a_timeout_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wdog_timeout_i |=> flags[core_regs_pkg::BIT_WDOG])
    else $error("timeout lost");
  a_flags_upper_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !alu_valid_i && !halt_i && !wdog_clear_i && !wdog_timeout_i
      |=> flags[7:4] == $past(flags[7:4]))
    else $error("upper flags changed by write");
  a_port_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && is_port(eff_addr) |=> rdat == 8'h00)
    else $error("indirect port read not zero");
  a_sign_from_wrap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i && alu_i.op == core_regs_pkg::OP_ADD |=>
      flags[core_regs_pkg::BIT_SIGN] == (flags[core_regs_pkg::BIT_WRAP]
        ^ acc[7]))
    else $error("sign compare mismatch");
  a_zero_flag_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i && alu_i.op != core_regs_pkg::OP_NONE |=>
      flags[core_regs_pkg::BIT_ZERO] == (acc == 8'h00))
    else $error("zero flag mismatch");
  a_table_split: assert property (
    @(posedge clk_i) disable iff (rst_i)
    table_read_i |=> tbl_data == $past(table_word_i[15:8])
      && tlow_out == $past(table_word_i[7:0]))
    else $error("table word split wrong");
  // A bus write to the flags in the same cycle would win, so skip it
  a_nibble_from_alu: assert property (
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i && !wr && (alu_i.op == core_regs_pkg::OP_ADD ||
      alu_i.op == core_regs_pkg::OP_SUB) |=>
      flags[core_regs_pkg::BIT_NIBBLE] == $past(alu_i.nibble))
    else $error("nibble carry mismatch");

endmodule

// ==== verif/exec_unit_model.sv ====
// Behavioural execution unit that faces the register block.
// Assumes one rising-edge clock and a bench that calls its tasks in turn.
module exec_unit_model (
  input  wire logic               clk_i,
  output core_regs_pkg::alu_res_t alu_o,
  output logic                    alu_valid_o,
  output logic                    wdog_clear_o,
  output logic                    halt_o,
  output logic                    wdog_timeout_o,
  output logic                    table_read_o,
  output logic [15:0]             table_word_o,
  output logic [4:0]              pc_page_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Idle state at time zero
  initial begin
    alu_o = '0;
    alu_valid_o = 1'b0;
    wdog_clear_o = 1'b0;
    halt_o = 1'b0;
    wdog_timeout_o = 1'b0;
    table_read_o = 1'b0;
    table_word_o = 16'h0000;
    pc_page_o = 5'h00;
  end

  // ==========================================================
  // One result pulse; the released bus flips so stale data never matches
  task automatic issue(input core_regs_pkg::alu_res_t r);
    @(posedge clk_i);
    alu_o <= r;
    alu_valid_o <= 1'b1;
    @(posedge clk_i);
    alu_valid_o <= 1'b0;
    alu_o <= core_regs_pkg::alu_res_t'(~r);
  endtask

  // Single-cycle system events, ordered timeout, clear, halt
  task automatic events(input logic [2:0] e);
    @(posedge clk_i);
    {wdog_timeout_o, wdog_clear_o, halt_o} <= e;
    @(posedge clk_i);
    {wdog_timeout_o, wdog_clear_o, halt_o} <= 3'h0;
  endtask

  // Program word fetch for a table read, word not held afterwards
  task automatic fetch(input logic [15:0] w);
    @(posedge clk_i);
    table_read_o <= 1'b1;
    table_word_o <= w;
    @(posedge clk_i);
    table_read_o <= 1'b0;
    table_word_o <= ~w;
  endtask

  // Current program page seen by the block
  task automatic set_page(input logic [4:0] p);
    @(posedge clk_i);
    pc_page_o <= p;
  endtask
endmodule

// ==== verif/core_special_registers_bench.sv ====
// Self-checking bench for the core special-function register block.
// Assumes the execution-unit model and a 10 MHz clock with sync reset.
module core_special_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    core_regs_pkg::alu_res_t in;
    logic [7:0]              flags;
  } alu_row_t;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } reg_row_t;

  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    wb_cyc = 1'b0;
  logic                    wb_stb = 1'b0;
  logic                    wb_we = 1'b0;
  logic [31:0]             wb_adr = 32'h0;
  logic [3:0]              wb_sel = 4'h0;
  logic [31:0]             wb_dat = 32'h0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o;
  core_regs_pkg::alu_res_t alu;
  logic                    alu_valid, wdog_clear, halt, wdog_timeout;
  logic                    table_read;
  logic [15:0]             table_word, table_addr_o;
  logic [4:0]              pc_page;
  logic [7:0]              acc_o, alu_flags_o, table_low_o, rd;
  logic [12:0]             jump_target_o;
  logic                    jump_o, dummy_cycle_o;
  int                      n_errors = 0;
  int                      tests_run = 0;
  int                      n;
  logic [3:0]              sel_lane = 4'h1;
  logic                    jump_d = 1'b0;
  logic                    jump_seen = 1'b0;
  logic                    dummy_after = 1'b0;
  logic [12:0]             target_seen = 13'h0000;

  // Hand-worked flag bytes, bit 7 down: sign, chain, wdog, halted,
  // wrap, zero, nibble, carry
  alu_row_t alu_rows [10] = '{
    '{'{core_regs_pkg::OP_ADD,   8'h00, 1'b1, 1'b1, 1'b0}, 8'h8f},
    '{'{core_regs_pkg::OP_SUB,   8'h00, 1'b1, 1'b0, 1'b1}, 8'h45},
    '{'{core_regs_pkg::OP_SBC,   8'h80, 1'b0, 1'b1, 1'b1}, 8'h0a},
    '{'{core_regs_pkg::OP_SBC,   8'h00, 1'b1, 1'b1, 1'b1}, 8'h07},
    '{'{core_regs_pkg::OP_SUB,   8'h7f, 1'b0, 1'b0, 1'b1}, 8'h88},
    '{'{core_regs_pkg::OP_LOGIC, 8'h00, 1'b1, 1'b1, 1'b0}, 8'h8c},
    '{'{core_regs_pkg::OP_ROTC,  8'h81, 1'b1, 1'b0, 1'b0}, 8'h89},
    '{'{core_regs_pkg::OP_SUB,   8'h00, 1'b1, 1'b1, 1'b1}, 8'h47},
    '{'{core_regs_pkg::OP_SBC,   8'h00, 1'b1, 1'b1, 1'b1}, 8'h47},
    '{'{core_regs_pkg::OP_ADD,   8'hff, 1'b0, 1'b0, 1'b0}, 8'hc0}};
  // Pointer, table and working-register bytes; sectors stay at 1 for the indirect tests
  reg_row_t reg_rows [8] = '{
    '{{1'b0, core_regs_pkg::ADDR_PTR_SECTOR0}, 8'ha5},
    '{{1'b0, core_regs_pkg::ADDR_PTR1_LOW},    8'h3c},
    '{{1'b0, core_regs_pkg::ADDR_PTR1_SECTOR}, 8'h01},
    '{{1'b0, core_regs_pkg::ADDR_PTR2_LOW},    8'hc3},
    '{{1'b0, core_regs_pkg::ADDR_PTR2_SECTOR}, 8'h01},
    '{{1'b0, core_regs_pkg::ADDR_TABLE_LOW},   8'h12},
    '{{1'b0, core_regs_pkg::ADDR_TABLE_HIGH},  8'h34},
    '{{1'b0, core_regs_pkg::ADDR_ACC},         8'h5a}};

  always #50 clk_i = ~clk_i;

  // Jump and dummy stand one cycle each, while the bus task is busy,
  // so latch them as they pass
  always @(posedge clk_i) begin
    jump_d <= jump_o;
    if (jump_o === 1'b1) begin
      jump_seen   <= 1'b1;
      target_seen <= jump_target_o;
    end
    if (dummy_cycle_o === 1'b1 && jump_d === 1'b1) begin
      dummy_after <= 1'b1;
    end
  end

  // ==========================================================
  // Design and far-side model
  core_special_registers uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .alu_i(alu), .alu_valid_i(alu_valid), .wdog_clear_i(wdog_clear),
    .halt_i(halt), .wdog_timeout_i(wdog_timeout),
    .table_read_i(table_read), .table_word_i(table_word),
    .pc_page_i(pc_page), .acc_o(acc_o), .alu_flags_o(alu_flags_o),
    .jump_target_o(jump_target_o), .jump_o(jump_o),
    .dummy_cycle_o(dummy_cycle_o), .table_addr_o(table_addr_o),
    .table_low_o(table_low_o));
  exec_unit_model exec_model (
    .clk_i(clk_i), .alu_o(alu), .alu_valid_o(alu_valid),
    .wdog_clear_o(wdog_clear), .halt_o(halt),
    .wdog_timeout_o(wdog_timeout), .table_read_o(table_read),
    .table_word_o(table_word), .pc_page_o(pc_page));

  // ==========================================================
  // Verdict, the only place the run ends
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // Classic cycle; the leading edge gives the idle gap after a release
  task automatic wb_xfer(input logic w, input logic [8:0] a,
                         input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= sel_lane;
    wb_adr <= {21'h0, a, 2'b00};
    wb_dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end else begin
      q = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
    end
  endtask

  // Flags are registered, so give the update two edges to land
  task automatic flags_are(input logic [7:0] f);
    repeat (2) @(posedge clk_i);
    check("alu_flags_o", {8'h00, f}, {8'h00, alu_flags_o});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("alu_flags_o", 16'h0000, {8'h00, alu_flags_o});
    foreach (alu_rows[i]) begin
      exec_model.issue(alu_rows[i].in);
      flags_are(alu_rows[i].flags);
      check("acc_o", {8'h00, alu_rows[i].in.result}, {8'h00, acc_o});
    end
    foreach (reg_rows[i]) begin
      wb_xfer(1'b1, reg_rows[i].addr, reg_rows[i].data, rd);
      wb_xfer(1'b0, reg_rows[i].addr, 8'h00, rd);
      check("register", {8'h00, reg_rows[i].data}, {8'h00, rd});
    end
    check("table_addr_o", 16'h3412, table_addr_o);
    exec_model.fetch(16'habcd);
    repeat (2) @(posedge clk_i);
    check("table_low_o", 16'h00cd, {8'h00, table_low_o});
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_TABLE_DATA}, 8'h00, rd);
    check("table data high", 16'h00ab, {8'h00, rd});
    // Same location in both sectors holds different bytes
    wb_xfer(1'b1, 9'h0f0, 8'h11, rd);
    wb_xfer(1'b1, 9'h1f0, 8'h77, rd);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_PTR_SECTOR0}, 8'hf0, rd);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_PTR1_LOW}, 8'hf0, rd);
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_INDIRECT_0}, 8'h00, rd);
    check("port 0 read", 16'h0011, {8'h00, rd});
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_INDIRECT_1}, 8'h00, rd);
    check("port 1 read", 16'h0077, {8'h00, rd});
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_PTR2_LOW}, 8'h80, rd);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_INDIRECT_2}, 8'h99, rd);
    wb_xfer(1'b0, 9'h180, 8'h00, rd);
    check("port 2 write", 16'h0099, {8'h00, rd});
    // Pointer aimed at a port: no storage behind it
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_PTR_SECTOR0}, 8'h02, rd);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_INDIRECT_0}, 8'h55, rd);
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_INDIRECT_0}, 8'h00, rd);
    check("port via port", 16'h0000, {8'h00, rd});
    // Jump inside the current page, then one dummy cycle
    exec_model.set_page(5'h03);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_PC_LOW}, 8'h44, rd);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dummy_after !== 1'b1 && n < 4);
    check("jump_o", 16'h0001, {15'h0, jump_seen});
    check("jump_target_o", 16'h0344, {3'h0, target_seen});
    check("dummy_cycle_o", 16'h0001, {15'h0, dummy_after});
    if (dummy_after !== 1'b1) begin
      tally_and_finish();
    end
    exec_model.events(3'b100);
    flags_are(8'he0);
    exec_model.events(3'b001);
    flags_are(8'hd0);
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_ALU_FLAGS}, 8'hff, rd);
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_ALU_FLAGS}, 8'h00, rd);
    check("flags by bus", 16'h00df, {8'h00, rd});
    exec_model.events(3'b100);
    flags_are(8'hff);
    exec_model.events(3'b010);
    flags_are(8'hcf);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("flags after reset", 16'h0000, {8'h00, alu_flags_o});
    check("acc after reset", 16'h0000, {8'h00, acc_o});
    // A write without lane 0 selected leaves the register alone
    sel_lane = 4'h2;
    wb_xfer(1'b1, {1'b0, core_regs_pkg::ADDR_ACC}, 8'hee, rd);
    sel_lane = 4'h1;
    wb_xfer(1'b0, {1'b0, core_regs_pkg::ADDR_ACC}, 8'h00, rd);
    check("acc lane write", 16'h0000, {8'h00, rd});
    tally_and_finish();
  end
endmodule
